// ---- rtl/smwc_defines.svh ----
`ifndef SMWC_DEFINES_SVH
`define SMWC_DEFINES_SVH

// Register byte offsets
`define SMWC_CTRL_OFS      8'h00
`define SMWC_STATUS_OFS    8'h04
`define SMWC_MASK_OFS      8'h08
`define SMWC_STATE_OFS     8'h0c

// Control field positions
`define SMWC_CME_BIT       0
`define SMWC_SELF_CLOCK_MODE_ENABLE_BIT      1
`define SMWC_SELF_CLOCK_IRQ_ENABLE_BIT     2
`define SMWC_PSEUDO_STOP_SELECT_BIT      3
`define SMWC_PLL_CLOCK_SELECT_BIT    4
`define SMWC_CTRL_W        5
`define SMWC_CTRL_RST      5'h03

// Status field positions
`define SMWC_ST_SELF_CLOCK_IRQ_FLAG      0
`define SMWC_ST_WAKE       1
`define SMWC_ST_CMFAIL     2
`define SMWC_ST_RECOVER    3
`define SMWC_STATUS_W      4
`define SMWC_STATUS_RST    4'h0
`define SMWC_MASK_RST      4'h0

// Clock quality check timing
`define SMWC_QC_OK_CYCLES  4096
`define SMWC_MAX_WINDOWS   50

`endif

// ---- rtl/smwc_pkg.sv ----
package smwc_pkg;
  typedef enum logic [1:0] {
    ST_RUN,
    ST_PSTOP,
    ST_FSTOP,
    ST_FCHECK
  } smwc_state_type;
endpackage

// ---- rtl/smwc_stop_wakeup.sv ----
`timescale 1ns/1ps
`include "smwc_defines.svh"
module smwc_stop_wakeup #(
  parameter int QC_OK_CYCLES = `SMWC_QC_OK_CYCLES,
  parameter int MAX_WINDOWS  = `SMWC_MAX_WINDOWS
) (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          stopReq,
  input  wire logic                          externalReset,
  input  wire logic                          wakeIrq,
  input  wire logic                          clockLoss,
  input  wire logic                          oscActive,
  output logic                               resetGenStart,
  output logic                               monitorFailReset,
  output logic                               selfClockMode,
  output logic                               pllEnable,
  output logic                               regulatorEnable,
  output logic                               clocksReleased,
  output logic                               pllClockSelect,
  output logic                               selfClockIrq,
  output logic                               irq,
  output smwc_pkg::smwc_state_type           modeState,
  input  wire logic [7:0]                    s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [7:0]                    s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready
);
  import smwc_pkg::*;

  localparam int WCW = $clog2(QC_OK_CYCLES + 1);
  localparam int NCW = $clog2(MAX_WINDOWS + 1);

  smwc_state_type              state_q;
  logic [`SMWC_CTRL_W-1:0]     ctrl_q;
  logic [`SMWC_STATUS_W-1:0]   status_q;
  logic [`SMWC_STATUS_W-1:0]   mask_q;
  logic [`SMWC_STATUS_W-1:0]   evSet;
  logic                        scm_q;
  logic                        resetPending_q;
  logic [WCW-1:0]              winCnt_q;
  logic                        winBad_q;
  logic [NCW-1:0]              winNum_q;
  logic                        checkActive;
  logic                        winEnd;
  logic                        winOk;
  logic                        clock_monitor_enable;
  logic                        self_clock_mode_enable;
  logic                        self_clock_irq_enable;
  logic                        cmFire;
  logic                        lastWindow;
  logic                        resetGen_q;
  logic                        monFail_q;
  logic [7:0]                  awAddr_q;
  logic                        awHave_q;
  logic [31:0]                 wData_q;
  logic [3:0]                  wStrb_q;
  logic                        wHave_q;
  logic                        doWrite;
  logic                        wrCtrl;
  logic                        wrStatus;
  logic                        wrMask;
  logic                        wrHit;

  assign clock_monitor_enable   = ctrl_q[`SMWC_CME_BIT];
  assign self_clock_mode_enable  = ctrl_q[`SMWC_SELF_CLOCK_MODE_ENABLE_BIT];
  assign self_clock_irq_enable = ctrl_q[`SMWC_SELF_CLOCK_IRQ_ENABLE_BIT];

  // --------------------------------------------------------------
  // Clock quality check windows
  // --------------------------------------------------------------
  // Check runs in self-clock mode (not in full stop) and after full-stop wake
  assign checkActive = (scm_q && state_q != ST_FSTOP) || state_q == ST_FCHECK;
  assign winEnd      = checkActive && winCnt_q == WCW'(QC_OK_CYCLES - 1);
  assign winOk       = winEnd && !winBad_q && oscActive;
  assign lastWindow  = winNum_q == NCW'(MAX_WINDOWS - 1);
  // Loss seen by the monitor only in pseudo-stop with monitor enabled
  assign cmFire      = state_q == ST_PSTOP && clockLoss && clock_monitor_enable && !scm_q && !externalReset;

  always_ff @(posedge clk) begin
    if (rst || !checkActive || winEnd) begin
      winCnt_q <= '0;
      winBad_q <= 1'b0;
    end else begin
      winCnt_q <= winCnt_q + WCW'(1);
      winBad_q <= winBad_q | ~oscActive;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || state_q != ST_FCHECK) begin
      winNum_q <= '0;
    end else if (winEnd && !winOk && !lastWindow) begin
      winNum_q <= winNum_q + NCW'(1);
    end
  end

  // --------------------------------------------------------------
  // Mode sequencing
  // --------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q        <= ST_RUN;
      resetPending_q <= 1'b0;
      resetGen_q     <= 1'b0;
      monFail_q      <= 1'b0;
    end else begin
      resetGen_q <= 1'b0;
      monFail_q  <= 1'b0;
      case (state_q)
        ST_RUN: begin
          if (stopReq) begin
            state_q <= ctrl_q[`SMWC_PSEUDO_STOP_SELECT_BIT] ? ST_PSTOP : ST_FSTOP;
          end
        end
        ST_PSTOP: begin
          if (externalReset) begin
            resetGen_q <= 1'b1;
            state_q    <= ST_RUN;
          end else if (cmFire && !self_clock_mode_enable) begin
            monFail_q  <= 1'b1;
            resetGen_q <= 1'b1;
            state_q    <= ST_RUN;
          end else if (cmFire && self_clock_irq_enable) begin
            state_q <= ST_RUN;
          end else if (wakeIrq) begin
            state_q <= ST_RUN;
          end
        end
        ST_FSTOP: begin
          if (externalReset) begin
            resetPending_q <= 1'b1;
            state_q        <= ST_FCHECK;
          end else if (wakeIrq) begin
            resetPending_q <= 1'b0;
            state_q        <= ST_FCHECK;
          end
        end
        ST_FCHECK: begin
          if (externalReset) begin
            resetPending_q <= 1'b1;
          end
          if (winOk) begin
            resetGen_q <= resetPending_q | externalReset;
            state_q    <= ST_RUN;
          end else if (winEnd && lastWindow) begin
            if (!self_clock_mode_enable) begin
              monFail_q <= 1'b1;
            end
            resetGen_q <= !self_clock_mode_enable || resetPending_q || externalReset;
            state_q    <= ST_RUN;
          end
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  // Self-clock mode entry on clock loss and exit on a good window
  always_ff @(posedge clk) begin
    if (rst) begin
      scm_q <= 1'b0;
    end else if (state_q == ST_PSTOP && clockLoss && clock_monitor_enable && self_clock_mode_enable && !scm_q
                 && !externalReset) begin
      scm_q <= 1'b1;
    end else if (state_q == ST_FCHECK && winEnd && !winOk && lastWindow && self_clock_mode_enable) begin
      scm_q <= 1'b1;
    end else if (winOk) begin
      scm_q <= 1'b0;
    end
  end

  assign resetGenStart    = resetGen_q;
  assign monitorFailReset = monFail_q;
  assign selfClockMode    = scm_q;
  assign modeState        = state_q;
  // PLL and regulator stay up only for self-clock mode in pseudo-stop
  assign pllEnable        = state_q == ST_RUN || (scm_q && state_q == ST_PSTOP);
  assign regulatorEnable  = state_q == ST_RUN || (scm_q && state_q == ST_PSTOP);
  assign clocksReleased   = state_q == ST_RUN;
  assign pllClockSelect   = ctrl_q[`SMWC_PLL_CLOCK_SELECT_BIT] && !scm_q;

  // --------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------
  assign doWrite  = awHave_q && wHave_q && !s_axi_bvalid;
  assign wrCtrl   = doWrite && awAddr_q == `SMWC_CTRL_OFS && wStrb_q[0];
  assign wrStatus = doWrite && awAddr_q == `SMWC_STATUS_OFS && wStrb_q[0];
  assign wrMask   = doWrite && awAddr_q == `SMWC_MASK_OFS && wStrb_q[0];
  assign wrHit    = awAddr_q == `SMWC_CTRL_OFS || awAddr_q == `SMWC_STATUS_OFS
                    || awAddr_q == `SMWC_MASK_OFS || awAddr_q == `SMWC_STATE_OFS;

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= `SMWC_CTRL_RST;
    end else if (externalReset && (state_q == ST_PSTOP || state_q == ST_FSTOP)) begin
      ctrl_q <= `SMWC_CTRL_RST;
    end else if (cmFire && !self_clock_mode_enable) begin
      ctrl_q <= `SMWC_CTRL_RST;
    end else if (stopReq && state_q == ST_RUN) begin
      ctrl_q[`SMWC_PLL_CLOCK_SELECT_BIT] <= 1'b0;
    end else if (wrCtrl) begin
      ctrl_q <= wData_q[`SMWC_CTRL_W-1:0];
    end
  end

  always_comb begin
    evSet = '0;
    evSet[`SMWC_ST_SELF_CLOCK_IRQ_FLAG]   = state_q == ST_PSTOP && clockLoss && clock_monitor_enable && self_clock_mode_enable && !scm_q
                              && !externalReset;
    evSet[`SMWC_ST_WAKE]    = (state_q == ST_PSTOP || state_q == ST_FSTOP) && wakeIrq;
    evSet[`SMWC_ST_CMFAIL]  = (cmFire && !self_clock_mode_enable)
                              || (state_q == ST_FCHECK && winEnd && !winOk && lastWindow && !self_clock_mode_enable);
    evSet[`SMWC_ST_RECOVER] = winOk && scm_q;
  end

  // Set wins over a write-one-to-clear in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      status_q <= `SMWC_STATUS_RST;
    end else if (wrStatus) begin
      status_q <= (status_q & ~wData_q[`SMWC_STATUS_W-1:0]) | evSet;
    end else begin
      status_q <= status_q | evSet;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mask_q <= `SMWC_MASK_RST;
    end else if (wrMask) begin
      mask_q <= wData_q[`SMWC_STATUS_W-1:0];
    end
  end

  assign irq          = |(status_q & mask_q);
  assign selfClockIrq = status_q[`SMWC_ST_SELF_CLOCK_IRQ_FLAG] && self_clock_irq_enable;

  // --------------------------------------------------------------
  // AXI4-Lite slave
  // --------------------------------------------------------------
  assign s_axi_awready = !awHave_q;
  assign s_axi_wready  = !wHave_q;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk) begin
    if (rst) begin
      awHave_q     <= 1'b0;
      wHave_q      <= 1'b0;
      awAddr_q     <= '0;
      wData_q      <= '0;
      wStrb_q      <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_q <= {s_axi_awaddr[7:2], 2'h0};
        awHave_q <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
        wHave_q <= 1'b1;
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrHit ? 2'h0 : 2'h2;
        awHave_q     <= 1'b0;
        wHave_q      <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'h0;
      s_axi_rdata  <= '0;
      case ({s_axi_araddr[7:2], 2'h0})
        `SMWC_CTRL_OFS:   s_axi_rdata[`SMWC_CTRL_W-1:0]   <= ctrl_q;
        `SMWC_STATUS_OFS: s_axi_rdata[`SMWC_STATUS_W-1:0] <= status_q;
        `SMWC_MASK_OFS:   s_axi_rdata[`SMWC_STATUS_W-1:0] <= mask_q;
        `SMWC_STATE_OFS:  s_axi_rdata[3:0]                <= {resetPending_q, scm_q, state_q};
        default:          s_axi_rresp                     <= 2'h2;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  property p_ext_pstop;
    @(posedge clk) disable iff (rst)
    state_q == ST_PSTOP && externalReset |=>
      resetGenStart && state_q == ST_RUN && ctrl_q == `SMWC_CTRL_RST;
  endproperty
  a_ext_pstop: assert property (p_ext_pstop) else $error("ext reset in pseudo-stop");

  property p_cm_reset;
    @(posedge clk) disable iff (rst)
    cmFire && !self_clock_mode_enable |=> monitorFailReset && resetGenStart && status_q[`SMWC_ST_CMFAIL];
  endproperty
  a_cm_reset: assert property (p_cm_reset) else $error("no monitor-fail reset");

  property p_scm_wake;
    @(posedge clk) disable iff (rst)
    cmFire && self_clock_mode_enable && self_clock_irq_enable |=> state_q == ST_RUN && selfClockMode && selfClockIrq;
  endproperty
  a_scm_wake: assert property (p_scm_wake) else $error("self-clock wake missing");

  property p_scm_stay;
    @(posedge clk) disable iff (rst)
    cmFire && self_clock_mode_enable && !self_clock_irq_enable && !wakeIrq |=>
      state_q == ST_PSTOP && status_q[`SMWC_ST_SELF_CLOCK_IRQ_FLAG] && pllEnable && regulatorEnable;
  endproperty
  a_scm_stay: assert property (p_scm_stay) else $error("self-clock stay wrong");

  property p_wake;
    @(posedge clk) disable iff (rst)
    state_q == ST_PSTOP && wakeIrq && !externalReset && !clockLoss |=>
      state_q == ST_RUN && !resetGenStart;
  endproperty
  a_wake: assert property (p_wake) else $error("wake-up not taken");

  property p_cm_off;
    @(posedge clk) disable iff (rst)
    state_q == ST_PSTOP && !clock_monitor_enable && !scm_q && clockLoss && !wakeIrq && !externalReset |=>
      state_q == ST_PSTOP && !selfClockMode && !monitorFailReset;
  endproperty
  a_cm_off: assert property (p_cm_off) else $error("loss acted on with monitor off");

  property p_recover;
    @(posedge clk) disable iff (rst)
    scm_q && state_q == ST_PSTOP && winOk && !wakeIrq && !externalReset |=>
      !selfClockMode && !pllEnable && !regulatorEnable;
  endproperty
  a_recover: assert property (p_recover) else $error("recovery not applied");

  property p_window_len;
    @(posedge clk) disable iff (rst)
    checkActive && !winEnd |=> winCnt_q == $past(winCnt_q) + WCW'(1);
  endproperty
  a_window_len: assert property (p_window_len) else $error("window length wrong");

  property p_fstop_quiet;
    @(posedge clk) disable iff (rst)
    state_q == ST_FSTOP |=> !monitorFailReset && !resetGenStart;
  endproperty
  a_fstop_quiet: assert property (p_fstop_quiet) else $error("action in full stop");

  property p_win_bound;
    @(posedge clk) disable iff (rst)
    state_q == ST_FCHECK && winEnd && !winOk && !lastWindow |=>
      state_q == ST_FCHECK && winNum_q == $past(winNum_q) + NCW'(1);
  endproperty
  a_win_bound: assert property (p_win_bound) else $error("too many windows");

  property p_timeout;
    @(posedge clk) disable iff (rst)
    state_q == ST_FCHECK && winEnd && !winOk && lastWindow |=>
      state_q == ST_RUN && (selfClockMode || monitorFailReset);
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout outcome wrong");

  property p_pll_clock_select_clear;
    @(posedge clk) disable iff (rst)
    state_q == ST_RUN && stopReq |=> !pllClockSelect;
  endproperty
  a_pll_clock_select_clear: assert property (p_pll_clock_select_clear) else $error("PLL select kept");

  c_scm_wake:  cover property (@(posedge clk) disable iff (rst) cmFire && self_clock_mode_enable && self_clock_irq_enable);
  c_recover:   cover property (@(posedge clk) disable iff (rst) winOk && scm_q);
  c_fcheck_ok: cover property (@(posedge clk) disable iff (rst) state_q == ST_FCHECK && winOk);
  c_timeout:   cover property (@(posedge clk) disable iff (rst) winEnd && lastWindow);
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb;
  import smwc_pkg::*;
  localparam int QC = 16;
  localparam int MW = 3;
  logic clk, rst, stopReq, externalReset, wakeIrq, clockLoss, oscActive;
  logic resetGenStart, monitorFailReset, selfClockMode, pllEnable, regulatorEnable;
  logic clocksReleased, pllClockSelect, selfClockIrq, irq;
  smwc_state_type modeState;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          n_errors = 0, checked = 0, nRgs = 0, nMfr = 0, er = 0, em = 0, nw;
  typedef struct {
    logic wr; logic [7:0] a; logic [31:0] wd; logic [1:0] br; logic [31:0] rd; logic [1:0] rr;
  } smwc_row_type;
  smwc_row_type rows [9] = '{
    '{1'h0, 8'h00, 32'h0, 2'h0, 32'h03, 2'h0}, '{1'h0, 8'h04, 32'h0, 2'h0, 32'h0, 2'h0},
    '{1'h0, 8'h08, 32'h0, 2'h0, 32'h0, 2'h0}, '{1'h0, 8'h0c, 32'h0, 2'h0, 32'h0, 2'h0},
    '{1'h0, 8'h10, 32'h0, 2'h0, 32'h0, 2'h2}, '{1'h1, 8'h08, 32'h0f, 2'h0, 32'h0f, 2'h0},
    '{1'h1, 8'h00, 32'h1f, 2'h0, 32'h1f, 2'h0}, '{1'h1, 8'h0c, 32'hff, 2'h0, 32'h0, 2'h0},
    '{1'h1, 8'h14, 32'h05, 2'h2, 32'h0, 2'h2}};

  smwc_stop_wakeup #(.QC_OK_CYCLES(QC), .MAX_WINDOWS(MW)) dut (.*);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Pulse outputs stand one cycle, so each is seen once at the falling edge
  always @(negedge clk) begin
    if (resetGenStart === 1'b1) nRgs++;
    if (monitorFailReset === 1'b1) nMfr++;
  end

  // ---------------------------------------------
  // Checking and bus tasks
  // ---------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_st(input smwc_state_type got, input smwc_state_type exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: state %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic settle;
    @(negedge clk);
  endtask
  task automatic endt(input string s);
    $display("test %s done", s);
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic aw, w, ha, hw, g;
    s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
    aw = 1'b1; w = 1'b1; g = 1'b0;
    while (aw || w) begin
      settle; ha = aw && (s_axi_awready === 1'b1); hw = w && (s_axi_wready === 1'b1);
      @(posedge clk);
      if (ha) begin s_axi_awvalid <= 1'b0; aw = 1'b0; end
      if (hw) begin s_axi_wvalid <= 1'b0; w = 1'b0; end
    end
    s_axi_bready <= 1'b1;
    while (!g) begin
      settle; g = (s_axi_bvalid === 1'b1); rs = s_axi_bresp;
      @(posedge clk);
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic h, g;
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; h = 1'b0; g = 1'b0;
    while (!h) begin
      settle; h = (s_axi_arready === 1'b1);
      @(posedge clk);
    end
    s_axi_arvalid <= 1'b0; s_axi_rready <= 1'b1;
    while (!g) begin
      settle; g = (s_axi_rvalid === 1'b1); v = s_axi_rdata; rs = s_axi_rresp;
      @(posedge clk);
    end
    s_axi_rready <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    axi_read(a, d, r); chk(d, exp);
  endtask
  task automatic ev(input int k);
    if (k == 0) externalReset <= 1'b1;
    else if (k == 1) clockLoss <= 1'b1;
    else wakeIrq <= 1'b1;
    cyc(1);
    externalReset <= 1'b0; clockLoss <= 1'b0; wakeIrq <= 1'b0;
  endtask
  // Waits for run mode (k=0) or for self-clock mode to end (k=1)
  task automatic wait_for(input int k, input int mx);
    nw = 0; settle;
    while (!((k == 0 && modeState === ST_RUN) || (k == 1 && selfClockMode === 1'b0)) && nw < mx)
    begin
      @(posedge clk); settle; nw++;
    end
    chk(nw < mx, 1'b1);
    @(posedge clk);
  endtask
  task automatic cnts;
    settle; chk(nRgs, er); chk(nMfr, em); cyc(1);
  endtask
  task automatic enter(input logic [7:0] c);
    axi_write(8'h04, 32'h0f, r); axi_write(8'h00, {24'h0, c}, r);
    stopReq <= 1'b1; cyc(1); stopReq <= 1'b0; cyc(2); settle;
    chk_st(modeState, c[3] ? ST_PSTOP : ST_FSTOP);
    chk(pllClockSelect, 1'b0);
    cyc(1);
  endtask

  initial begin
    #100000;
    n_errors++;
    report_and_stop;
  end

  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial begin
    rst = 1'b1; stopReq = 1'b0; externalReset = 1'b0; wakeIrq = 1'b0; clockLoss = 1'b0;
    oscActive = 1'b1; s_axi_awaddr = 8'h0; s_axi_awvalid = 1'b0; s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0; s_axi_araddr = 8'h0;
    s_axi_arvalid = 1'b0; s_axi_rready = 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    settle; chk_st(modeState, ST_RUN); chk(s_axi_bvalid, 1'b0); chk(irq, 1'b0); cyc(1);
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        axi_write(rows[i].a, rows[i].wd, r); chk(r, rows[i].br);
      end
      axi_read(rows[i].a, d, r); chk(d, rows[i].rd); chk(r, rows[i].rr);
    end
    settle; chk(pllClockSelect, 1'b1); cyc(1);
    endt("registers");
    enter(8'h1c); ev(0); er++; wait_for(0, 8);
    cnts();
    rdchk(8'h00, 32'h03);
    endt("ext_reset_pseudo_stop");
    enter(8'h19); ev(1); er++; em++; wait_for(0, 8);
    cnts();
    endt("monitor_fail_reset");
    enter(8'h1a); ev(1); cyc(3); settle;
    chk_st(modeState, ST_PSTOP); chk(selfClockMode, 1'b0); cyc(1);
    ev(2); wait_for(0, 3);
    rdchk(8'h04, 32'h02);
    axi_write(8'h08, 32'h0, r); settle; chk(irq, 1'b0); cyc(1);
    axi_write(8'h08, 32'h02, r); settle; chk(irq, 1'b1); cyc(1);
    axi_write(8'h04, 32'h02, r); settle; chk(irq, 1'b0); cyc(1);
    endt("wake_irq_and_monitor_off");
    enter(8'h0f); ev(1); wait_for(0, 4);
    settle; chk(selfClockMode, 1'b1); chk(selfClockIrq, 1'b1); cyc(1);
    wait_for(1, QC + 6);
    endt("self_clock_irq_wake");
    oscActive <= 1'b0; enter(8'h0b); ev(1); cyc(3); settle;
    chk_st(modeState, ST_PSTOP); chk(selfClockIrq, 1'b0);
    chk(selfClockMode, 1'b1); chk(pllEnable, 1'b1); chk(regulatorEnable, 1'b1);
    cyc(1); rdchk(8'h04, 32'h01);
    oscActive <= 1'b1; wait_for(1, 2 * QC + 6);
    settle; chk(nw >= QC - 2, 1'b1); chk_st(modeState, ST_PSTOP);
    chk(pllEnable, 1'b0); chk(regulatorEnable, 1'b0); cyc(1);
    ev(2); wait_for(0, 4);
    settle; chk(selfClockMode, 1'b0); chk(clocksReleased, 1'b1); cyc(1);
    endt("recovery_in_pseudo_stop");
    oscActive <= 1'b0; enter(8'h0b); ev(1); cyc(3 * QC); settle;
    chk_st(modeState, ST_PSTOP); chk(selfClockMode, 1'b1); cyc(1);
    ev(0); er++; wait_for(0, 8);
    settle; chk(selfClockMode, 1'b1); cyc(1);
    cnts();
    oscActive <= 1'b1; wait_for(1, 2 * QC + 6);
    endt("no_recovery");
    enter(8'h11); ev(1); cyc(3); settle; chk_st(modeState, ST_FSTOP); cyc(1);
    ev(2); wait_for(0, QC + 8);
    settle; chk(nw >= QC - 2, 1'b1); chk(clocksReleased, 1'b1); cyc(1);
    cnts();
    axi_write(8'h00, 32'h11, r); settle; chk(pllClockSelect, 1'b1); cyc(1);
    endt("full_stop_wake");
    oscActive <= 1'b0; enter(8'h02); ev(2); wait_for(0, MW * QC + 8);
    settle; chk(nw >= MW * QC - 2, 1'b1); chk(selfClockMode, 1'b1); cyc(1);
    cnts();
    oscActive <= 1'b1; wait_for(1, 2 * QC + 6);
    oscActive <= 1'b0; enter(8'h00); ev(2); er++; em++; wait_for(0, MW * QC + 8);
    oscActive <= 1'b1; cnts();
    endt("full_stop_timeout");
    enter(8'h00); ev(0); er++; wait_for(0, QC + 8);
    settle; chk(nw >= QC - 2, 1'b1); cyc(1);
    cnts();
    rdchk(8'h00, 32'h03);
    endt("ext_reset_full_stop");
    enter(8'h08); rst <= 1'b1; cyc(2); rst <= 1'b0;
    settle; chk_st(modeState, ST_RUN); cyc(1);
    rdchk(8'h00, 32'h03);
    endt("reset_in_stop");
    report_and_stop;
  end
endmodule
